// ===== rtl/sacc_pkg.sv
// Purpose: Shared constants and types for the serial converter control block
// Assumes: 40 MHz system clock
// Notes:   Timing counts derive from the figures here, except the select settle count and the SVA limits, which are literals
package sacc_pkg;

  localparam int RES_BITS        = 8;
  localparam int SHIFT_EDGES     = 8;
  localparam int SAMPLE_EDGE     = 4;
  localparam int HOLD_CYCLES     = 4;
  localparam int CONV_CYCLES     = 32;
  localparam int TOTAL_CYCLES    = HOLD_CYCLES + CONV_CYCLES;
  localparam int CLK_PERIOD_NS   = 25;
  localparam int INT_CLK_NS      = 250;
  localparam int INT_DIV         = INT_CLK_NS / CLK_PERIOD_NS;
  localparam int CONV_MAX_US     = 17;
  localparam int CONV_MAX_CYC    = (CONV_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int CS_SETTLE_EDGES = 3;
  localparam logic [7:0] RESULT_RST = 8'h00;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'b0_0001,
    ST_SETTLE = 5'b0_0010,
    ST_SHIFT  = 5'b0_0100,
    ST_HOLD   = 5'b0_1000,
    ST_CONV   = 5'b1_0000
  } sacc_state_t;

  typedef struct packed {
    logic sample;
    logic hold;
    logic busy;
  } sacc_status_t;

endpackage

// ===== rtl/sacc_sar.sv
// Purpose: Successive-approximation engine, one bit per internal tick
// Assumes: Comparator answer is analog_gt_i, sampled through two flops
// Notes:   Abort stops the engine and leaves the last result untouched
`timescale 1ns/1ps
module sacc_sar
  import sacc_pkg::*;
#(
  parameter int WIDTH = RES_BITS
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  // Control
  input  wire logic             start_i,
  input  wire logic             abort_i,
  input  wire logic             tick_i,
  input  wire logic             cmp_i,
  // Result
  output logic [WIDTH-1:0]      trial_o,
  output logic [WIDTH-1:0]      result_o,
  output logic                  done_o
);

  logic [WIDTH-1:0] trial_r, trial_nxt;
  logic [WIDTH-1:0] bit_r,   bit_nxt;
  logic             run_r,   run_nxt;
  logic             done_r,  done_nxt;

  always_comb begin
    trial_nxt = trial_r;
    bit_nxt   = bit_r;
    run_nxt   = run_r;
    done_nxt  = 1'b0;
    if (abort_i) begin
      run_nxt = 1'b0;
    end else if (start_i) begin
      run_nxt   = 1'b1;
      bit_nxt   = {1'b1, {(WIDTH-1){1'b0}}};
      trial_nxt = {1'b1, {(WIDTH-1){1'b0}}};
    end else if (run_r && tick_i) begin
      // Keep or drop the trial bit, then try the next lower one
      trial_nxt = (cmp_i ? trial_r : (trial_r & ~bit_r)) | (bit_r >> 1);
      bit_nxt   = bit_r >> 1;
      if (bit_r[0]) begin
        run_nxt  = 1'b0;
        done_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      trial_r <= '0;
      bit_r   <= '0;
      run_r   <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      trial_r <= trial_nxt;
      bit_r   <= bit_nxt;
      run_r   <= run_nxt;
      done_r  <= done_nxt;
    end
  end

  assign trial_o  = trial_r;
  assign result_o = trial_r;
  assign done_o   = done_r;

endmodule

// ===== rtl/sacc_top.sv
// Purpose: Control logic of a serially read 8-bit converter
// Assumes: Select and shift clock come from another domain; 40 MHz clk_i
// Notes:   Internal conversion clock is a divided tick of clk_i
// Operation
// - Select high: output off, shift ignored
// - Respond after two rises, one fall internal
// - First four falls shift bits two-five
// - Sampling starts after fourth falling edge
// - Falls five-seven shift bits six-eight
// - Hold begins at eighth falling edge
// - Hold four cycles, convert thirty-two more
// - Glitches under held select lose alignment
// - Select fall aborts conversion, resets logic
// - Early new sequence aborts, keeps old result
// - Conversion clock independent of shift clock
// - Result stored in eight-bit data register
// - Conversion finishes within 17 microseconds
`timescale 1ns/1ps
module sacc_top
  import sacc_pkg::*;
#(
  parameter int DIV = INT_DIV
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_i,
  // Serial link
  input  wire logic chip_select_n_i,
  input  wire logic serial_shift_clock_i,
  output logic      serial_result_out_o,
  output logic      serial_result_oe_o,
  // Analog front end
  input  wire logic analog_gt_i,
  output logic      sample_o,
  output logic      hold_o,
  output logic      busy_o
);

  localparam logic [5:0] TOTAL_C = 6'(TOTAL_CYCLES);
  localparam logic [5:0] HOLD_C  = 6'(HOLD_CYCLES);
  localparam logic [3:0] DIV_C   = 4'(DIV);

  // Synchronisers for pins
  logic [1:0] cs_sync_r, sck_sync_r, cmp_sync_r;
  logic       cs_d_r, sck_d_r;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cs_sync_r  <= 2'b11;
      sck_sync_r <= 2'b00;
      cmp_sync_r <= 2'b00;
      cs_d_r     <= 1'b1;
      sck_d_r    <= 1'b0;
    end else begin
      cs_sync_r  <= {cs_sync_r[0], chip_select_n_i};
      sck_sync_r <= {sck_sync_r[0], serial_shift_clock_i};
      cmp_sync_r <= {cmp_sync_r[0], analog_gt_i};
      cs_d_r     <= cs_sync_r[1];
      sck_d_r    <= sck_sync_r[1];
    end
  end

  logic cs_n, cs_fall, sck_fall;
  assign cs_n     = cs_sync_r[1];
  assign cs_fall  = cs_d_r & ~cs_n;
  assign sck_fall = sck_d_r & ~sck_sync_r[1] & ~cs_n;

  // Internal system clock: free running tick, phase tracked for settle
  logic [3:0] div_r, div_nxt;
  logic       tick, tick_rise, tick_fall;
  always_comb begin
    div_nxt = (div_r == DIV_C - 4'h1) ? 4'h0 : div_r + 4'h1;
  end
  assign tick      = (div_r == DIV_C - 4'h1);
  assign tick_rise = tick;
  assign tick_fall = (div_r == (DIV_C >> 1) - 4'h1);
  always_ff @(posedge clk_i) begin
    if (reset_i) div_r <= 4'h0;
    else         div_r <= div_nxt;
  end

  // Control state
  sacc_state_t state_r, state_nxt;
  logic [3:0]  edges_r, edges_nxt;
  logic [5:0]  cyc_r,   cyc_nxt;
  logic [1:0]  rise_r,  rise_nxt;
  logic        fall_r,  fall_nxt;
  logic [7:0]  shreg_r, shreg_nxt;
  logic [7:0]  data_r,  data_nxt;
  logic        dout_r,  dout_nxt;
  logic        oe_r,    oe_nxt;
  logic        samp_r,  samp_nxt;
  logic        hold_r,  hold_nxt;
  logic        busy_r,  busy_nxt;
  logic        sar_start, sar_abort, conv_end;
  logic [7:0]  sar_result;

  sacc_sar #(.WIDTH(RES_BITS)) u_sar (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .start_i  (sar_start),
    .abort_i  (sar_abort),
    .tick_i   (tick),
    .cmp_i    (cmp_sync_r[1]),
    .trial_o  (),
    .result_o (sar_result),
    .done_o   ()
  );

  // Result lands only after the full tick budget, so an abort keeps the old one
  assign conv_end = (state_r == ST_CONV) && tick && (cyc_r + 6'd1 == TOTAL_C);

  always_comb begin
    state_nxt = state_r;
    edges_nxt = edges_r;
    cyc_nxt   = cyc_r;
    rise_nxt  = rise_r;
    fall_nxt  = fall_r;
    shreg_nxt = shreg_r;
    data_nxt  = data_r;
    dout_nxt  = dout_r;
    oe_nxt    = ~cs_n;
    samp_nxt  = samp_r;
    hold_nxt  = hold_r;
    busy_nxt  = busy_r;
    sar_start = 1'b0;
    sar_abort = 1'b0;
    if (conv_end) begin
      data_nxt = sar_result;
    end
    if (cs_fall) begin
      // Fresh sequence: drop any running conversion
      sar_abort = 1'b1;
      state_nxt = ST_SETTLE;
      rise_nxt  = 2'd0;
      fall_nxt  = 1'b0;
      edges_nxt = 4'd0;
      samp_nxt  = 1'b0;
      hold_nxt  = 1'b0;
      busy_nxt  = 1'b0;
      shreg_nxt = conv_end ? sar_result : data_r;
      dout_nxt  = conv_end ? sar_result[7] : data_r[7];
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (!cs_n && sck_fall) begin
            // Select held low across conversions
            state_nxt = ST_SHIFT;
            edges_nxt = 4'd0;
            shreg_nxt = data_r;
            dout_nxt  = data_r[7];
          end
        end
        ST_SETTLE: begin
          if (tick_rise && rise_r != 2'd2) rise_nxt = rise_r + 2'd1;
          if (tick_fall && rise_r != 2'd0) fall_nxt = 1'b1;
          if (rise_r == 2'd2 && fall_r) state_nxt = ST_SHIFT;
        end
        ST_SHIFT: begin
          if (sck_fall) begin
            edges_nxt = edges_r + 4'd1;
            shreg_nxt = {shreg_r[6:0], 1'b0};
            dout_nxt  = shreg_r[6];
            if (edges_r + 4'd1 == 4'(SAMPLE_EDGE)) samp_nxt = 1'b1;
            if (edges_r + 4'd1 == 4'(SHIFT_EDGES)) begin
              samp_nxt  = 1'b0;
              hold_nxt  = 1'b1;
              busy_nxt  = 1'b1;
              cyc_nxt   = 6'd0;
              sar_abort = 1'b1;
              state_nxt = ST_HOLD;
            end
          end
        end
        ST_HOLD: begin
          if (tick) cyc_nxt = cyc_r + 6'd1;
          if (tick && cyc_r + 6'd1 == HOLD_C) begin
            sar_start = 1'b1;
            state_nxt = ST_CONV;
          end
        end
        ST_CONV: begin
          if (tick) cyc_nxt = cyc_r + 6'd1;
          if (conv_end) begin
            // 36 ticks at 4 MHz in all: well under 17 us
            hold_nxt  = 1'b0;
            busy_nxt  = 1'b0;
            state_nxt = ST_IDLE;
          end
        end
        default: state_nxt = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_r <= ST_IDLE;
      edges_r <= 4'd0;
      cyc_r   <= 6'd0;
      rise_r  <= 2'd0;
      fall_r  <= 1'b0;
      shreg_r <= RESULT_RST;
      data_r  <= RESULT_RST;
      dout_r  <= 1'b0;
      oe_r    <= 1'b0;
      samp_r  <= 1'b0;
      hold_r  <= 1'b0;
      busy_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      edges_r <= edges_nxt;
      cyc_r   <= cyc_nxt;
      rise_r  <= rise_nxt;
      fall_r  <= fall_nxt;
      shreg_r <= shreg_nxt;
      data_r  <= data_nxt;
      dout_r  <= dout_nxt;
      oe_r    <= oe_nxt;
      samp_r  <= samp_nxt;
      hold_r  <= hold_nxt;
      busy_r  <= busy_nxt;
    end
  end

  assign serial_result_out_o = dout_r;
  assign serial_result_oe_o  = oe_r;
  assign sample_o            = samp_r;
  assign hold_o              = hold_r;
  assign busy_o              = busy_r;

endmodule

// ===== verification/sacc_top_sva.sv
// Purpose: Port checks for the converter control block
// Assumes: Bound to sacc_top; select counts cover the synchroniser delay
// Notes:   Abort bound allows for the select settle time
`timescale 1ns/1ps
module sacc_top_sva
  import sacc_pkg::*;
#(
  parameter int DIV = INT_DIV
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Watched ports
  input wire logic chip_select_n_i,
  input wire logic serial_result_oe_o,
  input wire logic sample_o,
  input wire logic hold_o,
  input wire logic busy_o
);
  localparam int CONV_LIM = 680;
  logic [2:0] hi_r, lo_r, hi_nxt, lo_nxt;
  always_comb begin
    hi_nxt = !chip_select_n_i ? 3'h0 : (hi_r == 3'h7) ? hi_r : hi_r + 3'h1;
    lo_nxt = chip_select_n_i ? 3'h0 : (lo_r == 3'h7) ? lo_r : lo_r + 3'h1;
  end
  always_ff @(posedge clk_i) begin
    hi_r <= reset_i ? 3'h0 : hi_nxt;
    lo_r <= reset_i ? 3'h0 : lo_nxt;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  oe_off_a: assert property (hi_r >= 3'h5 |-> !serial_result_oe_o)
    else $error("output driven while deselected");
  oe_on_a: assert property (lo_r >= 3'h5 |-> serial_result_oe_o)
    else $error("output not driven while selected");
  idle_quiet_a: assert property (hi_r >= 3'h5 |-> !sample_o)
    else $error("sampling while deselected");
  hold_busy_a: assert property (hold_o == busy_o)
    else $error("hold and busy disagree");
  sample_excl_a: assert property (!(sample_o && hold_o))
    else $error("sample and hold together");
  hold_edge_a: assert property ($fell(sample_o) |-> ##[0:1] hold_o)
    else $error("hold did not follow sampling");
  busy_src_a: assert property ($rose(busy_o) |-> $past(sample_o))
    else $error("conversion without sampling");
  hold_min_a: assert property ($rose(hold_o) |-> hold_o[*8])
    else $error("hold too short");
  conv_bound_a: assert property ($rose(busy_o) |-> ##[1:CONV_LIM] !busy_o)
    else $error("conversion too long");
  abort_cs_a: assert property ($fell(chip_select_n_i) && busy_o |-> ##[1:30] !busy_o)
    else $error("select fall did not abort");
  cover property ($rose(busy_o));
  cover property ($fell(sample_o));
  cover property ($fell(chip_select_n_i) && busy_o);
endmodule
bind sacc_top sacc_top_sva #(.DIV(DIV)) u_sva (.clk_i(clk_i), .reset_i(reset_i),
  .chip_select_n_i(chip_select_n_i), .serial_result_oe_o(serial_result_oe_o),
  .sample_o(sample_o), .hold_o(hold_o), .busy_o(busy_o));

// ===== verification/sacc_ctrl_model.sv
// Purpose: Controller model driving select and shift clock
// Assumes: 200 ns shift clock, idle low; pulses() toggles it outside frames
// Notes:   A released data line reads as the inverse of its last value
`timescale 1ns/1ps
module sacc_ctrl_model (
  // Link to device
  output logic      cs_n_o,
  output logic      sclk_o,
  input  wire logic dout_i,
  input  wire logic oe_i
);
  logic last_r;
  wire  line_w = oe_i ? dout_i : ~last_r;
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    last_r = 1'b0;
  end
  always @(dout_i or oe_i) if (oe_i) last_r = dout_i;
  // Bits are taken just before each falling edge
  task automatic readout(output logic [7:0] d);
    cs_n_o = 1'b0;
    #1000;
    for (int i = 7; i >= 0; i--) begin
      #100 sclk_o = 1'b1;
      #95 d[i] = line_w;
      #5 sclk_o = 1'b0;
    end
    #100 cs_n_o = 1'b1;
  endtask
  task automatic pulses();
    for (int i = 0; i < 8; i++) begin
      #100 sclk_o = 1'b1;
      #100 sclk_o = 1'b0;
    end
  endtask
endmodule

// ===== verification/sacc_top_tb_top.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: Comparator input steers every result bit the same way
// Notes:   Result all ones when input is above every trial level
`timescale 1ns/1ps
module sacc_top_tb_top
  import sacc_pkg::*;
;
  logic       clk_i, reset_i, cs_n, sclk, gt, dout, oe, sample, hold, busy;
  logic [7:0] d;
  int         err_count = 0;
  int         total_checks = 0;
  int         cyc = 0;
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  sacc_top #(.DIV(INT_DIV)) uut (.clk_i(clk_i), .reset_i(reset_i), .chip_select_n_i(cs_n),
    .serial_shift_clock_i(sclk), .serial_result_out_o(dout), .serial_result_oe_o(oe),
    .analog_gt_i(gt), .sample_o(sample), .hold_o(hold), .busy_o(busy));
  sacc_ctrl_model ctrl (.cs_n_o(cs_n), .sclk_o(sclk), .dout_i(dout), .oe_i(oe));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("Checks %0d, errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      err_count++;
      results();
    end
  end
  task automatic wait_idle();
    repeat (8) @(posedge clk_i);
    for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge clk_i);
    @(posedge clk_i);
    #2;
  endtask
  task automatic set_gt(input logic v);
    @(posedge clk_i);
    #2 gt = v;
  endtask
  task automatic t_idle_shift();
    ctrl.pulses();
    chk(8'(busy), 8'h00);
    chk(8'(oe), 8'h00);
  endtask
  task automatic t_first();
    set_gt(1'b1);
    ctrl.readout(d);
    chk(d, RESULT_RST);
    #200 chk(8'(busy), 8'h01);
    chk(8'(hold), 8'h01);
    wait_idle();
    chk(8'(hold), 8'h00);
  endtask
  task automatic t_convert();
    set_gt(1'b0);
    ctrl.readout(d);
    chk(d, 8'hff);
    wait_idle();
  endtask
  task automatic t_abort();
    set_gt(1'b1);
    ctrl.readout(d);
    chk(d, 8'h00);
    repeat (20) @(posedge clk_i);
    #2;
    chk(8'(busy), 8'h01);
    fork
      ctrl.readout(d);
      #900 chk(8'(busy), 8'h00);
    join
    chk(d, 8'h00);
    wait_idle();
    ctrl.readout(d);
    chk(d, 8'hff);
  endtask
  initial begin
    reset_i = 1'b1;
    gt = 1'b0;
    repeat (5) @(posedge clk_i);
    #2 reset_i = 1'b0;
    t_idle_shift();
    t_first();
    t_convert();
    t_abort();
    results();
  end
endmodule
